// file: hdl/amc_top.sv
`timescale 1ns/1ns
`include "amc_cfg.svh"
module amc_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Processor side
  input wire logic global_irq_en,
  input wire logic irq_ack,
  output logic irq_req,
  // Trigger sources 1 to 7
  input wire logic [6:0] trig_in,
  // Conversion core
  input wire logic [9:0] core_result,
  output logic conv_power,
  output logic conv_clk_tick,
  output logic conv_start,
  output logic conv_busy,
  output amc_pkg::amc_mux_s mux_sel
);
  logic [7:0] insel_q, insel_d;
  logic en_q, en_d, ate_q, ate_d, flag_q, flag_d, ie_q, ie_d;
  logic [2:0] ps_q, ps_d, src_q, src_d;
  logic busy_q, busy_d, long_q, long_d, init_q, init_d;
  logic [4:0] cnt_q, cnt_d;
  logic [6:0] applied_q, applied_d;
  logic [9:0] result_q, result_d;
  logic lock_q, lock_d, trig_prev_q, trig_lvl;
  logic start_q;
  logic [7:0] rdata_q, rdata_d;
  logic wr_csr, trig_rise, done, start, start_req;
  logic tick;

  // Converter clock divider
  amc_prescaler #(
    .CNT_W(7)
  ) u_presc (
    .ref_clk(ref_clk),
    .srst(srst),
    .enable(en_q),
    .sel(ps_q),
    .tick(tick)
  );

  // Channel and gain decode for the multiplexer
  function automatic amc_pkg::amc_mux_s decode(input logic [6:0] a);
    amc_pkg::amc_mux_s m;
    m = '0;
    m.ref_sel = a[6:5]; // R1
    m.gain = amc_pkg::AMC_GAIN_1X;
    case (a[4:3])
      2'b00: begin
        m.pos = a[2:0]; // R6
      end
      2'b01: begin
        m.diff = 1'b1;
        m.neg = a[2] ? 3'h2 : 3'h0; // R7
        m.pos = m.neg + {2'b00, a[0]};
        m.gain = a[1] ? amc_pkg::AMC_GAIN_200X
                      : amc_pkg::AMC_GAIN_10X; // R7
      end
      2'b10: begin
        m.diff = 1'b1;
        m.pos = a[2:0]; // R8
        m.neg = 3'h1;
      end
      default: begin
        if (a[2:1] == 2'b11) begin
          m.bandgap = !a[0]; // R6
          m.ground = a[0];
        end else begin
          m.diff = 1'b1;
          m.pos = a[2:0]; // R8
          m.neg = 3'h2;
        end
      end
    endcase
    return m;
  endfunction : decode

  // Selected trigger level and edge
  always_comb begin
    if (src_q == `AMC_TRIG_FREE) begin
      trig_lvl = 1'b0;
    end else begin
      trig_lvl = trig_in[src_q - 3'h1];
    end
    trig_rise = trig_lvl && !trig_prev_q; // R13
  end

  // Conversion sequencing
  always_comb begin
    wr_csr = reg_wr && (reg_addr == `AMC_ADDR_CSR);
    en_d = wr_csr ? reg_wdata[`AMC_CSR_EN] : en_q;
    done = busy_q && tick &&
      (cnt_q == (long_q ? `AMC_CONV_FIRST - 5'h1
                        : `AMC_CONV_NORMAL - 5'h1)); // R11
    start_req = (wr_csr && reg_wdata[`AMC_CSR_START]) // R10 R12
      || (ate_q && trig_rise) // R13
      || (ate_q && src_q == `AMC_TRIG_FREE && done); // R22
    start = en_d && start_req && (!busy_q || done);
    init_d = init_q;
    if (en_d && !en_q) begin
      init_d = 1'b1;
    end
    if (!en_d || start) begin
      init_d = 1'b0;
    end
    long_d = long_q;
    if (start) begin
      long_d = init_q || !en_q; // R11
    end
    busy_d = busy_q;
    if (!en_d) begin
      busy_d = 1'b0; // R9
    end else if (start) begin
      busy_d = 1'b1; // R12
    end else if (done) begin
      busy_d = 1'b0; // R12
    end
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = 5'h0;
    end else if (busy_q && tick) begin
      cnt_d = cnt_q + 5'h1;
    end
  end

  // Register writes, flag and result
  always_comb begin
    insel_d = insel_q;
    ate_d = ate_q;
    ie_d = ie_q;
    ps_d = ps_q;
    src_d = src_q;
    if (reg_wr && reg_addr == `AMC_ADDR_INSEL) begin
      insel_d = reg_wdata;
    end
    if (wr_csr) begin
      ate_d = reg_wdata[`AMC_CSR_ATE];
      ie_d = reg_wdata[`AMC_CSR_IE];
      ps_d = reg_wdata[2:0];
    end
    if (reg_wr && reg_addr == `AMC_ADDR_TRIG) begin
      src_d = reg_wdata[2:0];
    end
    applied_d = applied_q;
    if (!busy_q || done) begin
      applied_d = {insel_q[`AMC_INSEL_REF_HI:`AMC_INSEL_REF_LO],
                   insel_q[4:0]}; // R2
    end
    flag_d = flag_q;
    if (irq_ack || (wr_csr && reg_wdata[`AMC_CSR_FLAG])) begin
      flag_d = 1'b0; // R15
    end
    if (done) begin
      flag_d = 1'b1; // R14
    end
    result_d = result_q;
    if (done && !lock_q) begin
      result_d = core_result; // R19 R20
    end
    lock_d = lock_q;
    if (reg_rd && reg_addr == `AMC_ADDR_RES_LO) begin
      lock_d = 1'b1; // R20
    end else if (reg_rd && reg_addr == `AMC_ADDR_RES_HI) begin
      lock_d = 1'b0; // R20
    end
  end

  // Read data, alignment follows the live bit
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      `AMC_ADDR_INSEL: rdata_d = insel_q;
      `AMC_ADDR_CSR: rdata_d = {en_q, busy_q, ate_q, flag_q,
                                ie_q, ps_q}; // R12
      `AMC_ADDR_TRIG: rdata_d = {5'h00, src_q};
      `AMC_ADDR_RES_LO: begin
        rdata_d = insel_q[`AMC_INSEL_LAR]
          ? {result_q[1:0], 6'h00} : result_q[7:0]; // R4 R5 R21
      end
      `AMC_ADDR_RES_HI: begin
        rdata_d = insel_q[`AMC_INSEL_LAR]
          ? result_q[9:2] : {6'h00, result_q[9:8]}; // R4 R5 R21
      end
      default: rdata_d = 8'h00;
    endcase
    if (!reg_rd) begin
      rdata_d = 8'h00;
    end
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      insel_q <= `AMC_REG_RESET;
      en_q <= 1'b0;
      ate_q <= 1'b0;
      flag_q <= 1'b0;
      ie_q <= 1'b0;
      ps_q <= 3'h0;
      src_q <= 3'h0;
      busy_q <= 1'b0;
      long_q <= 1'b0;
      init_q <= 1'b0;
      cnt_q <= 5'h0;
      applied_q <= 7'h00;
      result_q <= 10'h000;
      lock_q <= 1'b0;
      trig_prev_q <= 1'b0;
      start_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      insel_q <= insel_d;
      en_q <= en_d; // R9
      ate_q <= ate_d;
      flag_q <= flag_d;
      ie_q <= ie_d;
      ps_q <= ps_d;
      src_q <= src_d;
      busy_q <= busy_d;
      long_q <= long_d;
      init_q <= init_d;
      cnt_q <= cnt_d;
      applied_q <= applied_d;
      result_q <= result_d;
      lock_q <= lock_d;
      trig_prev_q <= trig_lvl;
      start_q <= start;
      rdata_q <= rdata_d;
    end
  end

  // Outputs
  assign reg_rdata = rdata_q;
  assign irq_req = flag_q && ie_q && global_irq_en; // R16
  assign conv_power = en_q; // R9
  assign conv_clk_tick = tick; // R18
  assign conv_start = start_q;
  assign conv_busy = busy_q;
  assign mux_sel = decode(applied_q); // R1 R6 R7 R8

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  property p_abort;
    wr_csr && !reg_wdata[`AMC_CSR_EN] |=> !busy_q && !conv_power;
  endproperty
  a_abort: assert property (p_abort) // R9
    else $error("disable did not abort conversion");

  property p_zero_start;
    !busy_q && wr_csr && !reg_wdata[`AMC_CSR_START] && !ate_q
      |=> !busy_q;
  endproperty
  a_zero_start: assert property (p_zero_start) // R12
    else $error("writing zero to start began a conversion");

  property p_start_busy;
    wr_csr && reg_wdata[`AMC_CSR_EN] && reg_wdata[`AMC_CSR_START]
      && !busy_q |=> busy_q ##0 conv_start;
  endproperty
  a_start_busy: assert property (p_start_busy) // R10
    else $error("start write did not begin conversion");

  property p_length;
    done |-> cnt_q == (long_q ? 5'h18 : 5'h0c);
  endproperty
  a_length: assert property (p_length) // R11
    else $error("conversion length wrong");

  property p_first_long;
    start && !en_q |=> long_q;
  endproperty
  a_first_long: assert property (p_first_long) // R11
    else $error("first conversion after enable not long");

  property p_flag_set;
    done |=> flag_q ##0 !busy_q || conv_start;
  endproperty
  a_flag_set: assert property (p_flag_set) // R14
    else $error("completion did not set flag");

  property p_flag_clear;
    flag_q && irq_ack && !done |=> !flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) // R15
    else $error("vector did not clear flag");

  property p_irq;
    flag_q && ie_q && global_irq_en |-> irq_req;
  endproperty
  a_irq: assert property (p_irq) // R16
    else $error("interrupt not requested");

  property p_pending;
    busy_q && !done |=> $stable(applied_q);
  endproperty
  a_pending: assert property (p_pending) // R2
    else $error("selection changed mid conversion");

  property p_lock;
    lock_q && !(reg_rd && reg_addr == `AMC_ADDR_RES_HI)
      |=> $stable(result_q);
  endproperty
  a_lock: assert property (p_lock) // R20
    else $error("result updated while locked");

  property p_left;
    reg_rd && reg_addr == `AMC_ADDR_RES_HI && insel_q[`AMC_INSEL_LAR]
      |=> reg_rdata == $past(result_q[9:2]);
  endproperty
  a_left: assert property (p_left) // R5
    else $error("left adjusted high byte wrong");

  c_long_done: cover property (done && long_q);
  c_free_run: cover property (done ##1 conv_start && ate_q);
  c_locked_drop: cover property (done && lock_q);
  c_irq: cover property (irq_req ##1 irq_ack);
endmodule : amc_top

// file: hdl/amc_cfg.svh
// Contract
// [R1] Reference field picks one of four references
// [R2] Reference and channel changes wait for completion
// [R3] Software uses 2.56V with 10x/200x gain
// [R4] Left-adjust bit selects result alignment
// [R5] Alignment change shows at once
// [R6] Single-ended, bandgap and ground channel codes
// [R7] Differential gain codes with 10x/200x
// [R8] Unity-gain differential against input 1/2
// [R9] Enable powers converter; clearing aborts
// [R10] Start bit begins a conversion
// [R11] First conversion 25 clocks, later 13
// [R12] Start reads busy; writing zero ignored
// [R13] Auto trigger starts on rising edge
// [R14] Done flag set on completion
// [R15] Done flag cleared by vector or one
// [R16] Interrupt when flag, enable, global set
// [R17] Software avoids read-modify-write of control
// [R18] Prescaler divides by 2 up to 128
// [R19] Differential result in two's complement
// [R20] Low byte read locks result until high
// [R21] Result byte placement per alignment
// [R22] Trigger source zero means free running
// [R23] Prescaler held reset while disabled
`ifndef AMC_CFG_SVH
`define AMC_CFG_SVH
`define AMC_ADDR_INSEL 3'h0
`define AMC_ADDR_CSR 3'h1
`define AMC_ADDR_TRIG 3'h2
`define AMC_ADDR_RES_LO 3'h3
`define AMC_ADDR_RES_HI 3'h4
`define AMC_INSEL_REF_HI 7
`define AMC_INSEL_REF_LO 6
`define AMC_INSEL_LAR 5
`define AMC_CSR_EN 7
`define AMC_CSR_START 6
`define AMC_CSR_ATE 5
`define AMC_CSR_FLAG 4
`define AMC_CSR_IE 3
`define AMC_REG_RESET 8'h00
`define AMC_CONV_FIRST 5'h19
`define AMC_CONV_NORMAL 5'h0d
`define AMC_TRIG_FREE 3'h0
`endif

// file: hdl/amc_pkg.sv
package amc_pkg;
  typedef enum logic [1:0] {
    AMC_GAIN_1X,
    AMC_GAIN_10X,
    AMC_GAIN_200X
  } amc_gain_e;

  // Selection handed to the analog multiplexer
  typedef struct packed {
    logic [1:0] ref_sel;
    logic [2:0] pos;
    logic [2:0] neg;
    amc_gain_e gain;
    logic diff;
    logic bandgap;
    logic ground;
  } amc_mux_s;
endpackage : amc_pkg

// file: hdl/amc_prescaler.sv
`timescale 1ns/1ns
`include "amc_cfg.svh"
module amc_prescaler #(
  parameter int CNT_W = 7
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Control
  input wire logic enable,
  input wire logic [2:0] sel,
  // Converter clock tick
  output logic tick
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] lim;

  // Division limit: codes 0 and 1 divide by 2
  always_comb begin
    if (sel <= 3'h1) begin
      lim = CNT_W'(1); // R18
    end else begin
      lim = CNT_W'((1 << sel) - 1); // R18
    end
    tick = enable && (cnt_q == lim);
    if (!enable || tick) begin
      cnt_d = '0; // R23
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  // Counter register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  property p_div2_gap;
    @(posedge ref_clk) disable iff (srst)
    tick && enable && sel <= 3'h1 && $stable(sel) |=> !tick;
  endproperty
  a_div2_gap: assert property (p_div2_gap) // R18
    else $error("divide by two ticks back to back");

  property p_held_off;
    @(posedge ref_clk) disable iff (srst)
    !enable |-> !tick;
  endproperty
  a_held_off: assert property (p_held_off) // R23
    else $error("tick while disabled");
endmodule : amc_prescaler

// file: sim/amc_core_model.sv
`timescale 1ns/1ns
module amc_core_model (
  // Clock
  input wire logic ref_clk,
  // Conversion handshake
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire logic [9:0] sample,
  output logic [9:0] core_result
);
  logic [9:0] res_q = 10'h000;
  // Capture the value to convert, already in two's complement
  always @(posedge ref_clk) begin
    if (conv_start === 1'b1) begin
      res_q <= sample;
    end
  end
  // Stale outside a conversion, so show the inverse
  assign core_result = (conv_busy === 1'b1) ? res_q : ~res_q;
endmodule : amc_core_model

// file: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic ref_clk = 1'b0;
  logic srst, reg_wr, reg_rd, global_irq_en, irq_ack, irq_req, rd_q;
  logic conv_power, conv_clk_tick, conv_start, conv_busy;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [6:0] trig_in;
  logic [9:0] core_result, sample;
  amc_pkg::amc_mux_s mux_sel;
  logic [15:0] exp_q[$];
  int fail_count = 0;
  int checks_done = 0;
  int seed = 32'h2dc2d531;

  // Clock
  always #5 ref_clk = ~ref_clk;

  amc_top u_dut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .global_irq_en, .irq_ack, .irq_req, .trig_in,
    .core_result, .conv_power, .conv_clk_tick, .conv_start, .conv_busy,
    .mux_sel);

  amc_core_model u_core (.ref_clk, .conv_start, .conv_busy, .sample,
    .core_result);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  // Read: note the expected byte for the monitor
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(16'(e));
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask : rd

  // Count converter ticks while busy
  task automatic cnv(input int e);
    int n, t;
    n = 0;
    t = 0;
    while (conv_busy !== 1'b1 && t < 20) begin
      @(posedge ref_clk);
      t++;
    end
    while (conv_busy === 1'b1 && t < 5000) begin
      n += (conv_clk_tick === 1'b1);
      @(posedge ref_clk);
      t++;
    end
    if (e > 0) chk(16'(n), 16'(e));
  endtask : cnv

  // Converter tick period in system clocks
  task automatic per(input int e);
    int n;
    n = 0;
    while (conv_clk_tick !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (conv_clk_tick !== 1'b1 && n < 300);
    chk(16'(n), 16'(e));
  endtask : per

  // Expected multiplexer selection; unused fields masked
  task automatic cmx(input logic [1:0] r, input logic [4:0] c);
    amc_pkg::amc_mux_s e, g;
    e = '0;
    e.ref_sel = r;
    e.pos = c[2:0];
    e.diff = c[4] | c[3];
    if (c[4:3] == 2'b01) begin
      e.pos = {1'b0, c[2], c[0]};
      e.neg = {1'b0, c[2], 1'b0};
      e.gain = c[1] ? amc_pkg::AMC_GAIN_200X : amc_pkg::AMC_GAIN_10X;
    end
    if (c[4]) e.neg = c[3] ? 3'h2 : 3'h1;
    if (c[4:1] == 4'hf) begin
      e.diff = 1'b0;
      e.neg = 3'h0;
      e.pos = 3'h0;
      e.bandgap = ~c[0];
      e.ground = c[0];
    end
    #1;
    g = mux_sel;
    if (!e.diff) begin
      g.neg = '0;
      g.gain = amc_pkg::AMC_GAIN_1X;
    end
    if (e.bandgap | e.ground) g.pos = '0;
    chk(16'(g), 16'(e));
    @(posedge ref_clk);
  endtask : cmx

  // Compare each read with the oldest note
  always @(posedge ref_clk) begin
    if (rd_q === 1'b1) chk(16'(reg_rdata), exp_q.pop_front());
    rd_q <= reg_rd;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    global_irq_en = 1'b1;
    irq_ack = 1'b0;
    trig_in = 7'h00;
    sample = 10'h270;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h00);
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00);
    for (int c = 0; c < 32; c++) begin
      wr(3'h0, {c[1:0], 1'b0, c[4:0]});
      cmx(c[1:0], c[4:0]);
    end
    for (int p = 0; p < 8; p++) begin
      wr(3'h1, 8'h00);
      wr(3'h1, {5'h10, p[2:0]});
      per(p < 2 ? 2 : 1 << p);
    end
    wr(3'h1, 8'h00);
    wr(3'h0, 8'hed);
    wr(3'h1, 8'hc0);
    cnv(25);
    rd(3'h1, 8'h90);
    rd(3'h3, 8'h00);
    rd(3'h4, 8'h9c);
    wr(3'h0, 8'hcd);
    rd(3'h3, 8'h70);
    rd(3'h4, 8'h02);
    rd(3'h3, 8'h70);
    // Top bits differ from the locked result, so a lost lock shows
    sample <= {2'b01, 8'($random(seed))};
    wr(3'h1, 8'hd0);
    cnv(13);
    rd(3'h4, 8'h02);
    wr(3'h1, 8'hd0);
    wr(3'h0, 8'h41);
    rd(3'h1, 8'hc0);
    cmx(2'h3, 5'h0d);
    cnv(0);
    cmx(2'h1, 5'h01);
    rd(3'h3, sample[7:0]);
    rd(3'h4, {6'h00, sample[9:8]});
    // Interrupt request, masking and acknowledge
    wr(3'h1, 8'h88);
    #1;
    chk(16'(irq_req), 16'h1);
    @(posedge ref_clk);
    global_irq_en <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(16'(irq_req), 16'h0);
    @(posedge ref_clk);
    global_irq_en <= 1'b1;
    @(posedge ref_clk);
    irq_ack <= 1'b1;
    @(posedge ref_clk);
    irq_ack <= 1'b0;
    rd(3'h1, 8'h88);
    // Abort by disabling
    wr(3'h1, 8'hc0);
    wr(3'h1, 8'h00);
    #1;
    chk(16'({conv_busy, conv_power}), 16'h0);
    @(posedge ref_clk);
    // Auto trigger, then free running
    wr(3'h2, 8'h01);
    wr(3'h1, 8'ha0);
    trig_in <= 7'h01;
    cnv(25);
    wr(3'h2, 8'h00);
    wr(3'h1, 8'he0);
    repeat (40) @(posedge ref_clk);
    rd(3'h1, 8'hf0);
    close_out();
  end
endmodule : tb_top
